// ==== src/nps_pkg.sv ====
/*
 * Shared constants and types for the power-up sequencer pair.
 * Assumes a single 125 MHz clock shared by both ends.
 */
package nps_pkg;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int SELECT_DELAY_MS = 1;
    localparam int WRITE_INHIBIT_DELAY_MS = 5;
    localparam int SELECT_DELAY_CYC = SELECT_DELAY_MS * 1000 * CLK_MHZ;
    localparam int WRITE_INHIBIT_DELAY_CYC = WRITE_INHIBIT_DELAY_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 24;

    // --------------------------------------------------------------
    // Auto-load target and command opcodes
    // --------------------------------------------------------------
    localparam logic [9:0] LOAD_BLOCK = 10'h000;
    localparam logic [5:0] LOAD_PAGE = 6'h00;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h10;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] OP_OTP_PROGRAM = 8'h8C;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h1F;
    localparam logic [7:0] OP_READ_CACHE = 8'h03;
    localparam logic [7:0] OP_READ_CACHE_FAST = 8'h0B;
    localparam logic [7:0] OP_READ_CACHE_QIO = 8'hEB;

    // --------------------------------------------------------------
    // Device and host sequencer states
    // --------------------------------------------------------------
    typedef enum logic [4:0] {
        DS_RESET = 5'h01,
        DS_LOAD = 5'h02,
        DS_INHIBIT = 5'h04,
        DS_READY = 5'h08,
        DS_SLEEP = 5'h10
    } nps_dev_state_t;

    typedef enum logic [3:0] {
        HS_OFF = 4'h1,
        HS_WAIT = 4'h2,
        HS_READ_OK = 4'h4,
        HS_ALL_OK = 4'h8
    } nps_host_state_t;

endpackage

// ==== src/nps_if.sv ====
/*
 * Carrier between the flash-side sequencer and the host-side gate.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/100ps
interface nps_if;
    logic select_b;
    logic cmd_valid;
    logic [7:0] cmd_op;
    logic cmd_accept;
    logic cmd_ignored;
    logic load_busy;

    modport device (
        input select_b, cmd_valid, cmd_op,
        output cmd_accept, cmd_ignored, load_busy
    );
    modport host (
        output select_b, cmd_valid, cmd_op,
        input cmd_accept, cmd_ignored, load_busy
    );
endinterface

// ==== src/nps_device.sv ====
/*
 * Flash-side power-up and wake-up sequencer: reset hold, write-inhibit
 * timing, initial state and the block 0 page 0 cache load request.
 * Assumes supply flags are synchronous and the array engine reports done.
 */
`timescale 1ns/100ps

// Notes on behaviour
// - Power-up loads block 0 page 0 with ECC.
// - Cache reads served after the load.
// - Sleep exit repeats the ECC page load.
// - Below threshold: reset, ignore all instructions.
// - Writes ignored until inhibit delay elapses.
// - Host withholds writes until both delays.
// - Reads accepted once select delay passed.
// - Host keeps select high until delay.
// - Power-up: standby, latch and busy cleared.
// - Supply drop disables operations immediately.
module nps_device #(
    // Delay counts in clock cycles; a bench may shorten them to keep runs brief.
    parameter int SELECT_CYC = nps_pkg::SELECT_DELAY_CYC,
    parameter int INHIBIT_CYC = nps_pkg::WRITE_INHIBIT_DELAY_CYC
) (
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    // Supply flags
    input wire logic ABOVE_THRESHOLD_I,
    input wire logic ABOVE_MIN_I,
    // Sleep control and array engine
    input wire logic SLEEP_ENTER_I,
    input wire logic SLEEP_EXIT_I,
    input wire logic LOAD_DONE_I,
    input wire logic WRITE_ENABLE_SET_I,
    input wire logic OPERATION_START_I,
    input wire logic OPERATION_DONE_I,
    // Serial bus side
    nps_if.device BUS,
    // Status outputs
    output logic LOGIC_RESET_O,
    output logic LOAD_REQ_O,
    output logic [9:0] LOAD_BLOCK_O,
    output logic [5:0] LOAD_PAGE_O,
    output logic LOAD_ECC_O,
    output logic STANDBY_O,
    output logic WRITE_ENABLE_LATCH_O,
    output logic OPERATION_IN_PROGRESS_O,
    output logic WRITE_ALLOWED_O
);

    nps_pkg::nps_dev_state_t state;
    logic [nps_pkg::CNT_W-1:0] inhibit_cnt;
    logic inhibit_done;
    logic [nps_pkg::CNT_W-1:0] vsl_cnt;
    logic vsl_done;
    logic powered;
    logic is_write_op;
    logic is_read_op;
    logic take;

    function automatic logic op_is_write(input logic [7:0] op);
        return op == nps_pkg::OP_WRITE_ENABLE || op == nps_pkg::OP_PAGE_PROGRAM ||
               op == nps_pkg::OP_BLOCK_ERASE || op == nps_pkg::OP_OTP_PROGRAM ||
               op == nps_pkg::OP_WRITE_STATUS;
    endfunction

    function automatic logic op_is_read(input logic [7:0] op);
        return op == nps_pkg::OP_READ_CACHE || op == nps_pkg::OP_READ_CACHE_FAST ||
               op == nps_pkg::OP_READ_CACHE_QIO;
    endfunction

    assign powered = ABOVE_THRESHOLD_I;
    assign is_write_op = op_is_write(BUS.cmd_op);
    assign is_read_op = op_is_read(BUS.cmd_op);
    assign take = BUS.cmd_valid && !BUS.select_b;

    // ------------------------------------------------------------------
    // Power-up timers
    // ------------------------------------------------------------------
    // write-inhibit counter
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            inhibit_cnt <= '0;
            inhibit_done <= 1'b0;
        end else if (!powered) begin
            inhibit_cnt <= '0;
            inhibit_done <= 1'b0;
        end else if (inhibit_cnt == nps_pkg::CNT_W'(INHIBIT_CYC - 1)) begin
            inhibit_done <= 1'b1;
        end else begin
            inhibit_cnt <= inhibit_cnt + 1'b1;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            vsl_cnt <= '0;
            vsl_done <= 1'b0;
        end else if (!powered || !ABOVE_MIN_I) begin
            vsl_cnt <= '0;
            vsl_done <= 1'b0;
        end else if (vsl_cnt == nps_pkg::CNT_W'(SELECT_CYC - 1)) begin
            vsl_done <= 1'b1;
        end else begin
            vsl_cnt <= vsl_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state <= nps_pkg::DS_RESET;
        end else if (!powered) begin
            state <= nps_pkg::DS_RESET;
        end else begin
            unique case (state)
                nps_pkg::DS_RESET: begin
                    state <= nps_pkg::DS_LOAD;
                end
                nps_pkg::DS_LOAD: begin
                    if (LOAD_DONE_I) begin
                        state <= inhibit_done ? nps_pkg::DS_READY : nps_pkg::DS_INHIBIT;
                    end
                end
                nps_pkg::DS_INHIBIT: begin
                    if (inhibit_done) begin
                        state <= nps_pkg::DS_READY;
                    end else if (SLEEP_ENTER_I) begin
                        state <= nps_pkg::DS_SLEEP;
                    end
                end
                nps_pkg::DS_READY: begin
                    if (SLEEP_ENTER_I) begin
                        state <= nps_pkg::DS_SLEEP;
                    end
                end
                nps_pkg::DS_SLEEP: begin
                    if (SLEEP_EXIT_I) begin
                        state <= nps_pkg::DS_LOAD;
                    end
                end
                default: state <= nps_pkg::DS_RESET;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Load request and outputs
    // ------------------------------------------------------------------
    // page load with ECC decode
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            LOAD_REQ_O <= 1'b0;
            LOAD_BLOCK_O <= nps_pkg::LOAD_BLOCK;
            LOAD_PAGE_O <= nps_pkg::LOAD_PAGE;
            LOAD_ECC_O <= 1'b0;
        end else begin
            LOAD_REQ_O <= powered && state == nps_pkg::DS_LOAD && !LOAD_DONE_I;
            LOAD_BLOCK_O <= nps_pkg::LOAD_BLOCK;
            LOAD_PAGE_O <= nps_pkg::LOAD_PAGE;
            LOAD_ECC_O <= powered && state == nps_pkg::DS_LOAD && !LOAD_DONE_I;
        end
    end

    // logic held in reset below threshold
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            LOGIC_RESET_O <= 1'b1;
            STANDBY_O <= 1'b0;
            WRITE_ALLOWED_O <= 1'b0;
        end else begin
            LOGIC_RESET_O <= !powered;
            STANDBY_O <= powered && state != nps_pkg::DS_RESET && state != nps_pkg::DS_SLEEP;
            WRITE_ALLOWED_O <= powered && inhibit_done;
        end
    end

    // latch and busy cleared at power-up
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            WRITE_ENABLE_LATCH_O <= 1'b0;
            OPERATION_IN_PROGRESS_O <= 1'b0;
        end else if (!powered || state == nps_pkg::DS_RESET) begin
            WRITE_ENABLE_LATCH_O <= 1'b0;
            OPERATION_IN_PROGRESS_O <= 1'b0;
        end else begin
            if (WRITE_ENABLE_SET_I && inhibit_done) begin
                WRITE_ENABLE_LATCH_O <= 1'b1;
            end else if (OPERATION_DONE_I) begin
                WRITE_ENABLE_LATCH_O <= 1'b0;
            end
            // A start in the same cycle as a done keeps the busy flag set.
            if (OPERATION_START_I && inhibit_done) begin
                OPERATION_IN_PROGRESS_O <= 1'b1;
            end else if (OPERATION_DONE_I) begin
                OPERATION_IN_PROGRESS_O <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Command gate
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            BUS.cmd_accept <= 1'b0;
            BUS.cmd_ignored <= 1'b0;
            BUS.load_busy <= 1'b1;
        end else begin
            BUS.load_busy <= !powered || state == nps_pkg::DS_RESET || state == nps_pkg::DS_LOAD;
            if (!take) begin
                BUS.cmd_accept <= 1'b0;
                BUS.cmd_ignored <= 1'b0;
            end else if (!powered || state == nps_pkg::DS_RESET) begin
                BUS.cmd_accept <= 1'b0;
                BUS.cmd_ignored <= 1'b1;
            end else if (is_write_op) begin
                BUS.cmd_accept <= inhibit_done && vsl_done;
                BUS.cmd_ignored <= !(inhibit_done && vsl_done);
            end else if (is_read_op) begin
                // cache reads once select delay passed and load done
                BUS.cmd_accept <= vsl_done && state != nps_pkg::DS_LOAD;
                BUS.cmd_ignored <= !(vsl_done && state != nps_pkg::DS_LOAD);
            end else begin
                BUS.cmd_accept <= vsl_done;
                BUS.cmd_ignored <= !vsl_done;
            end
        end
    end

endmodule // nps_device

// ==== src/nps_host.sv ====
/*
 * Host-side power-up gate: holds select high and withholds reads until
 * the select delay has passed, and writes until both delays have passed.
 * Assumes the same supply flags as the device, synchronous to the clock.
 */
`timescale 1ns/100ps
module nps_host #(
    // Delay counts in clock cycles; they must match those of the device.
    parameter int SELECT_CYC = nps_pkg::SELECT_DELAY_CYC,
    parameter int INHIBIT_CYC = nps_pkg::WRITE_INHIBIT_DELAY_CYC
) (
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    // Supply flags
    input wire logic ABOVE_THRESHOLD_I,
    input wire logic ABOVE_MIN_I,
    // User command port
    input wire logic REQ_VALID_I,
    input wire logic [7:0] REQ_OP_I,
    output logic REQ_READY_O,
    output logic REQ_DONE_O,
    output logic REQ_IGNORED_O,
    output logic READ_OK_O,
    output logic WRITE_OK_O,
    // Serial bus side
    nps_if.host BUS
);

    nps_pkg::nps_host_state_t state;
    logic [nps_pkg::CNT_W-1:0] vsl_cnt;
    logic [nps_pkg::CNT_W-1:0] puw_cnt;
    logic vsl_done;
    logic puw_done;
    logic pending;
    logic is_write;

    assign is_write = REQ_OP_I == nps_pkg::OP_WRITE_ENABLE || REQ_OP_I == nps_pkg::OP_PAGE_PROGRAM ||
                      REQ_OP_I == nps_pkg::OP_BLOCK_ERASE || REQ_OP_I == nps_pkg::OP_OTP_PROGRAM ||
                      REQ_OP_I == nps_pkg::OP_WRITE_STATUS;

    // ------------------------------------------------------------------
    // Delay counters
    // ------------------------------------------------------------------
    // select delay from minimum level
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            vsl_cnt <= '0;
            vsl_done <= 1'b0;
        end else if (!ABOVE_THRESHOLD_I || !ABOVE_MIN_I) begin
            vsl_cnt <= '0;
            vsl_done <= 1'b0;
        end else if (vsl_cnt == nps_pkg::CNT_W'(SELECT_CYC - 1)) begin
            vsl_done <= 1'b1;
        end else begin
            vsl_cnt <= vsl_cnt + 1'b1;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            puw_cnt <= '0;
            puw_done <= 1'b0;
        end else if (!ABOVE_THRESHOLD_I) begin
            puw_cnt <= '0;
            puw_done <= 1'b0;
        end else if (puw_cnt == nps_pkg::CNT_W'(INHIBIT_CYC - 1)) begin
            puw_done <= 1'b1;
        end else begin
            puw_cnt <= puw_cnt + 1'b1;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state <= nps_pkg::HS_OFF;
        end else if (!ABOVE_THRESHOLD_I || !ABOVE_MIN_I) begin
            state <= nps_pkg::HS_OFF;
        end else begin
            unique case (state)
                nps_pkg::HS_OFF: state <= nps_pkg::HS_WAIT;
                nps_pkg::HS_WAIT: if (vsl_done) state <= nps_pkg::HS_READ_OK;
                nps_pkg::HS_READ_OK: if (puw_done) state <= nps_pkg::HS_ALL_OK;
                nps_pkg::HS_ALL_OK: state <= nps_pkg::HS_ALL_OK;
                default: state <= nps_pkg::HS_OFF;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Command issue: one cycle of select low per command
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            BUS.select_b <= 1'b1;
            BUS.cmd_valid <= 1'b0;
            BUS.cmd_op <= 8'h00;
            pending <= 1'b0;
            REQ_READY_O <= 1'b0;
            REQ_DONE_O <= 1'b0;
            REQ_IGNORED_O <= 1'b0;
            READ_OK_O <= 1'b0;
            WRITE_OK_O <= 1'b0;
        end else begin
            READ_OK_O <= state == nps_pkg::HS_READ_OK || state == nps_pkg::HS_ALL_OK;
            WRITE_OK_O <= state == nps_pkg::HS_ALL_OK;
            REQ_DONE_O <= pending && BUS.cmd_accept;
            REQ_IGNORED_O <= pending && BUS.cmd_ignored;
            if (pending) begin
                BUS.select_b <= 1'b1;
                BUS.cmd_valid <= 1'b0;
                if (BUS.cmd_accept || BUS.cmd_ignored) begin
                    pending <= 1'b0;
                end
                REQ_READY_O <= 1'b0;
            end else if (BUS.cmd_valid) begin
                BUS.select_b <= 1'b1;
                BUS.cmd_valid <= 1'b0;
                pending <= 1'b1;
                REQ_READY_O <= 1'b0;
            end else if (REQ_VALID_I && REQ_READY_O) begin
                // select only after delay; writes after both
                BUS.select_b <= 1'b0;
                BUS.cmd_valid <= 1'b1;
                BUS.cmd_op <= REQ_OP_I;
                REQ_READY_O <= 1'b0;
            end else begin
                BUS.select_b <= 1'b1;
                REQ_READY_O <= (state == nps_pkg::HS_ALL_OK) ||
                               (state == nps_pkg::HS_READ_OK && !is_write);
            end
        end
    end

endmodule // nps_host

// ==== bench/nps_chk_sva.sv ====
/*
 * Link checker for the power-up sequencer pair.
 * Assumes it is instantiated beside the interface that joins both ends.
 */
`timescale 1ns/100ps
module nps_chk #(
    parameter int SEL = nps_pkg::SELECT_DELAY_CYC,
    parameter int WIN = nps_pkg::WRITE_INHIBIT_DELAY_CYC
) (
    // Clock, reset and supply
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    input wire logic ABOVE_THRESHOLD_I,
    input wire logic ABOVE_MIN_I,
    // Link
    input wire logic select_b,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_op,
    input wire logic cmd_accept,
    input wire logic cmd_ignored,
    input wire logic load_busy
);
    // Two cycles of slack absorb the flag registering on either end.
    localparam int SLACK = 2;
    logic [19:0] min_cnt;
    logic [19:0] thr_cnt;
    logic is_read;
    logic is_write;
    logic issue;
    logic answer;
    assign is_read = cmd_op inside {nps_pkg::OP_READ_CACHE, nps_pkg::OP_READ_CACHE_FAST, nps_pkg::OP_READ_CACHE_QIO};
    assign is_write = cmd_op inside {nps_pkg::OP_WRITE_ENABLE, nps_pkg::OP_PAGE_PROGRAM, nps_pkg::OP_BLOCK_ERASE,
        nps_pkg::OP_OTP_PROGRAM, nps_pkg::OP_WRITE_STATUS};
    assign issue = cmd_valid && !select_b;
    assign answer = cmd_accept || cmd_ignored;
    // ------------------------------------------------------------
    // Supply age counters
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            min_cnt <= '0;
        end else if (!ABOVE_MIN_I) begin
            min_cnt <= '0;
        end else if (min_cnt != 20'hFFFFF) begin
            min_cnt <= min_cnt + 20'h00001;
        end
    end
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            thr_cnt <= '0;
        end else if (!ABOVE_THRESHOLD_I) begin
            thr_cnt <= '0;
        end else if (thr_cnt != 20'hFFFFF) begin
            thr_cnt <= thr_cnt + 20'h00001;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_B_I);
    sequence seq_issue;
        issue;
    endsequence
    sequence seq_answer;
        ##[1:2] answer;
    endsequence
    a_select_held_off: assert property (!ABOVE_MIN_I && !$past(ABOVE_MIN_I) |-> select_b)
        else $error("select asserted before supply minimum");
    a_select_delay_kept: assert property (!select_b |-> int'(min_cnt) >= SEL - SLACK)
        else $error("select asserted before select delay");
    a_write_wait_both: assert property (seq_issue and is_write |-> int'(thr_cnt) >= WIN - SLACK
        && int'(min_cnt) >= SEL - SLACK)
        else $error("write command sent too early");
    a_answer_follows: assert property (seq_issue |-> seq_answer)
        else $error("command not answered");
    a_answer_caused: assert property (answer |-> $past(issue) || $past(issue, 2))
        else $error("answer without command");
    a_answer_single: assert property (answer |=> !answer)
        else $error("answer longer than one cycle");
    a_ignore_unpowered: assert property (issue && !ABOVE_THRESHOLD_I |-> ##[1:2] cmd_ignored)
        else $error("command served below threshold");
    a_ignore_write_early: assert property (issue && is_write && int'(thr_cnt) < WIN - SLACK |-> ##[1:2] cmd_ignored)
        else $error("write served during inhibit delay");
    a_read_served: assert property (issue && is_read && !load_busy && ABOVE_THRESHOLD_I
        && int'(min_cnt) >= SEL + SLACK |-> ##[1:2] cmd_accept)
        else $error("read refused after select delay");
    // Two cycles after the rise the busy flag reflects the state entered, so a skipped load shows.
    a_load_on_power: assert property ($rose(ABOVE_THRESHOLD_I) |-> ##2 load_busy)
        else $error("no page load at power-up");
endmodule // nps_chk

// ==== bench/nps_tb_top.sv ====
/*
 * Bench for the sequencer pair, plus a second device driven raw.
 * Runs both ends with shortened delay counts; the run lasts under 3k cycles.
 */
`timescale 1ns/100ps
module nand_powerup_sequencer_tb_top;
    // Shortened delays keep the run brief; their one-to-five ratio is kept.
    localparam int TB_SEL = 300;
    localparam int TB_WIN = 1500;
    localparam int TB_LIMIT = 4000;
    logic clock_i = 1'b0;
    logic rst_b = 1'b0;
    logic thr = 1'b0;
    logic vmin = 1'b0;
    logic sl_in = 1'b0;
    logic sl_out = 1'b0;
    logic ld_done = 1'b0;
    logic we_set = 1'b0;
    logic op_go = 1'b0;
    logic op_end = 1'b0;
    logic req_valid = 1'b0;
    logic [7:0] req_op = 8'h00;
    logic lrst, lreq, lecc, stby, write_enable_latch, operation_in_progress, wok2, lrst2;
    logic [9:0] lblk;
    logic [5:0] lpg;
    logic rdy, done, ign, rd_ok, wr_ok;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    logic [1:0] ans;
    logic [7:0] rd_ops [3] = '{nps_pkg::OP_READ_CACHE, nps_pkg::OP_READ_CACHE_FAST, nps_pkg::OP_READ_CACHE_QIO};
    logic [7:0] wr_ops [5] = '{nps_pkg::OP_WRITE_ENABLE, nps_pkg::OP_PAGE_PROGRAM, nps_pkg::OP_BLOCK_ERASE,
        nps_pkg::OP_OTP_PROGRAM, nps_pkg::OP_WRITE_STATUS};
    nps_if bus1();
    nps_if bus2();
    nps_device #(.SELECT_CYC(TB_SEL), .INHIBIT_CYC(TB_WIN)) nps_device_i (.CLOCK_I(clock_i), .RST_B_I(rst_b),
        .ABOVE_THRESHOLD_I(thr), .ABOVE_MIN_I(vmin),
        .SLEEP_ENTER_I(sl_in), .SLEEP_EXIT_I(sl_out), .LOAD_DONE_I(ld_done), .WRITE_ENABLE_SET_I(we_set),
        .OPERATION_START_I(op_go), .OPERATION_DONE_I(op_end), .BUS(bus1), .LOGIC_RESET_O(lrst),
        .LOAD_REQ_O(lreq), .LOAD_BLOCK_O(lblk), .LOAD_PAGE_O(lpg), .LOAD_ECC_O(lecc), .STANDBY_O(stby),
        .WRITE_ENABLE_LATCH_O(write_enable_latch), .OPERATION_IN_PROGRESS_O(operation_in_progress), .WRITE_ALLOWED_O(wok2));
    nps_host #(.SELECT_CYC(TB_SEL), .INHIBIT_CYC(TB_WIN)) nps_host_i (.CLOCK_I(clock_i), .RST_B_I(rst_b),
        .ABOVE_THRESHOLD_I(thr), .ABOVE_MIN_I(vmin),
        .REQ_VALID_I(req_valid), .REQ_OP_I(req_op), .REQ_READY_O(rdy), .REQ_DONE_O(done),
        .REQ_IGNORED_O(ign), .READ_OK_O(rd_ok), .WRITE_OK_O(wr_ok), .BUS(bus1));
    // Second device: the bench plays a host that breaks the select and write rules.
    nps_device #(.SELECT_CYC(TB_SEL), .INHIBIT_CYC(TB_WIN)) nps_device_raw_i (.CLOCK_I(clock_i), .RST_B_I(rst_b),
        .ABOVE_THRESHOLD_I(thr),
        .ABOVE_MIN_I(vmin), .SLEEP_ENTER_I(sl_in), .SLEEP_EXIT_I(sl_out), .LOAD_DONE_I(ld_done),
        .WRITE_ENABLE_SET_I(we_set), .OPERATION_START_I(op_go), .OPERATION_DONE_I(op_end), .BUS(bus2),
        .LOGIC_RESET_O(lrst2), .LOAD_REQ_O(), .LOAD_BLOCK_O(), .LOAD_PAGE_O(), .LOAD_ECC_O(), .STANDBY_O(),
        .WRITE_ENABLE_LATCH_O(), .OPERATION_IN_PROGRESS_O(), .WRITE_ALLOWED_O());
    nps_chk #(.SEL(TB_SEL), .WIN(TB_WIN)) nps_chk_i (.CLOCK_I(clock_i), .RST_B_I(rst_b), .ABOVE_THRESHOLD_I(thr),
        .ABOVE_MIN_I(vmin),
        .select_b(bus1.select_b), .cmd_valid(bus1.cmd_valid), .cmd_op(bus1.cmd_op),
        .cmd_accept(bus1.cmd_accept), .cmd_ignored(bus1.cmd_ignored), .load_busy(bus1.load_busy));
    initial begin
        forever #4 clock_i = ~clock_i;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clock_i);
    endtask
    task automatic finish_test();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Raw link command; ans is {accept, ignored}. The opcode is inverted once released.
    task automatic raw_cmd(input logic [7:0] op, input logic [1:0] exp);
        bus2.select_b = 1'b0;
        bus2.cmd_valid = 1'b1;
        bus2.cmd_op = op;
        cyc(1);
        bus2.select_b = 1'b1;
        bus2.cmd_valid = 1'b0;
        bus2.cmd_op = ~op;
        ans = 2'b00;
        repeat (3) begin
            ans = ans | {bus2.cmd_accept, bus2.cmd_ignored};
            cyc(1);
        end
        check(ans, exp);
        cyc(4);
    endtask
    // User request; ans is {done, ignored}.
    task automatic host_req(input logic [7:0] op, input logic [1:0] exp);
        req_valid = 1'b1;
        req_op = op;
        for (n = 0; n < 20 && rdy !== 1'b1; n++) cyc(1);
        cyc(1);
        req_valid = 1'b0;
        ans = 2'b00;
        repeat (6) begin
            ans = ans | {done, ign};
            cyc(1);
        end
        check(ans, exp);
    endtask
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == TB_LIMIT) begin
            failures++;
            finish_test();
        end
    end
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        bus2.select_b = 1'b1;
        bus2.cmd_valid = 1'b0;
        bus2.cmd_op = 8'h00;
        cyc(8);
        check({lrst, bus1.load_busy, bus1.select_b}, 3'h7);
        check({write_enable_latch, operation_in_progress}, 2'h0);
        rst_b = 1'b1;
        cyc(4);
        check(lrst2, 1'b1);
        raw_cmd(nps_pkg::OP_READ_CACHE, 2'b01);
        thr = 1'b1;
        vmin = 1'b1;
        cyc(3);
        check({lreq, lecc, lblk, lpg}, {2'b11, nps_pkg::LOAD_BLOCK, nps_pkg::LOAD_PAGE});
        raw_cmd(nps_pkg::OP_READ_CACHE, 2'b01);
        we_set = 1'b1;
        op_go = 1'b1;
        cyc(1);
        we_set = 1'b0;
        op_go = 1'b0;
        cyc(2);
        check({write_enable_latch, operation_in_progress}, 2'h0);
        ld_done = 1'b1;
        cyc(1);
        ld_done = 1'b0;
        cyc(2);
        check({lreq, bus1.load_busy, stby, write_enable_latch, operation_in_progress, wok2}, 6'h08);
        req_op = nps_pkg::OP_READ_CACHE;
        check({rd_ok, rdy}, 2'h0);
        cyc(TB_SEL - 40);
        check({rd_ok, bus1.select_b}, 2'h1);
        for (n = 0; n < 80 && rd_ok !== 1'b1; n++) cyc(1);
        check({rd_ok, wr_ok}, 2'h2);
        cyc(4);
        foreach (rd_ops[i]) begin
            host_req(rd_ops[i], 2'b10);
            raw_cmd(rd_ops[i], 2'b10);
        end
        foreach (wr_ops[i]) begin
            raw_cmd(wr_ops[i], 2'b01);
            req_op = wr_ops[i];
            cyc(2);
            check(rdy, 1'b0);
        end
        // Once the inhibit delay is over, writes pass on both links and the latch can be set.
        for (n = 0; n < TB_WIN && wr_ok !== 1'b1; n++) cyc(1);
        check({wr_ok, wok2}, 2'h3);
        foreach (wr_ops[i]) begin
            host_req(wr_ops[i], 2'b10);
            raw_cmd(wr_ops[i], 2'b10);
        end
        we_set = 1'b1;
        op_go = 1'b1;
        cyc(1);
        we_set = 1'b0;
        op_go = 1'b0;
        cyc(1);
        check({write_enable_latch, operation_in_progress}, 2'h3);
        op_end = 1'b1;
        cyc(1);
        op_end = 1'b0;
        cyc(1);
        check({write_enable_latch, operation_in_progress}, 2'h0);
        sl_in = 1'b1;
        cyc(1);
        sl_in = 1'b0;
        cyc(3);
        sl_out = 1'b1;
        cyc(1);
        sl_out = 1'b0;
        cyc(2);
        check({lreq, lecc, lblk, lpg}, {2'b11, nps_pkg::LOAD_BLOCK, nps_pkg::LOAD_PAGE});
        // A cache read while the wake-up load runs is refused.
        host_req(nps_pkg::OP_READ_CACHE, 2'b01);
        ld_done = 1'b1;
        cyc(1);
        ld_done = 1'b0;
        cyc(2);
        check(lreq, 1'b0);
        host_req(nps_pkg::OP_READ_CACHE, 2'b10);
        thr = 1'b0;
        cyc(3);
        check(lrst2, 1'b1);
        raw_cmd(nps_pkg::OP_READ_CACHE, 2'b01);
        finish_test();
    end
endmodule // nand_powerup_sequencer_tb_top
